// [core/stop_reset_status.sv]
// stop-mode sequencer and reset-source / break status registers
// assumes synchronous inputs and a single-cycle register port
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module stop_reset_status
(
	input wire logic clock,
	input wire logic srst,
	input wire logic stop_exec,
	input wire logic wait_exec,
	input wire logic irq_request,
	input wire logic break_request,
	input wire logic internal_slow_clock,
	input wire logic short_stop_recovery,
	input wire logic por_event,
	input wire logic pin_reset,
	input wire logic wdog_reset,
	input wire logic illegal_opcode_flag_reset,
	input wire logic illegal_address_flag_fetch_reset,
	input wire logic monitor_entry_flag_reset,
	input wire logic lvi_reset,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	output logic clocks_enable,
	output logic divided_osc_enable,
	output logic cpu_release,
	output logic in_stop,
	output logic flag_clear_allowed
);
	typedef enum logic [1:0] {run_s, stop_s, recover_s} mode_t;
	typedef struct packed {
		mode_t mode;
		logic [12:0] count;
		logic slow_prev;
		logic [7:0] rsrc;
		logic brk_exit;
		logic brk_clear;
		logic in_wait;
		logic wake_irq;
		logic [7:0] rdata;
		logic clk_en;
		logic release_p;
		logic fca;
		logic stopped;
	} state_t;
	state_t s_q;
	state_t s_d;
	logic slow_rise;
	logic any_reset;
	logic [12:0] target;
	logic wake;
	logic brk_set;

	// ==========================================================
	// next state
	always_comb
	begin
		s_d = s_q;
		slow_rise = internal_slow_clock & ~s_q.slow_prev;
		any_reset = pin_reset | wdog_reset | illegal_opcode_flag_reset | illegal_address_flag_fetch_reset
			| monitor_entry_flag_reset | lvi_reset;
		target = short_stop_recovery ? stop_reset_pkg::RECOVERY_SHORT
			: stop_reset_pkg::RECOVERY_LONG;
		wake = irq_request | break_request | any_reset;
		brk_set = 1'b0;
		s_d.slow_prev = internal_slow_clock;
		s_d.release_p = 1'b0;
		s_d.rdata = stop_reset_pkg::BYTE_ZERO;
		if (wait_exec)
		begin
			s_d.in_wait = 1'b1;
		end
		unique case (s_q.mode)
			run_s:
			begin
				if (stop_exec)
				begin
					s_d.mode = stop_s;
					s_d.count = '0;
					s_d.clk_en = 1'b0;
					s_d.stopped = 1'b1;
				end
				else if (s_q.in_wait && wake)
				begin
					s_d.in_wait = 1'b0;
					if (break_request)
					begin
						s_d.brk_exit = 1'b1;
						brk_set = 1'b1;
					end
				end
			end
			stop_s:
			begin
				s_d.count = '0;
				if (wake)
				begin
					s_d.mode = recover_s;
					s_d.wake_irq = 1'b1;
					if (break_request)
					begin
						s_d.brk_exit = 1'b1;
						brk_set = 1'b1;
					end
				end
			end
			recover_s:
			begin
				if (slow_rise)
				begin
					s_d.count = s_q.count + stop_reset_pkg::RECOVERY_ONE;
				end
				if (s_q.count >= target)
				begin
					s_d.mode = run_s;
					s_d.clk_en = 1'b1;
					s_d.stopped = 1'b0;
					s_d.release_p = 1'b1;
					s_d.wake_irq = 1'b0;
					s_d.count = '0;
				end
			end
			default:
			begin
				s_d.mode = run_s;
				s_d.stopped = 1'b0;
			end
		endcase
		// register port; set beats clear on break-exit flag
		if (reg_write && reg_addr == stop_reset_pkg::ADDR_BREAK_EXIT
			&& !reg_wdata[stop_reset_pkg::BIT_BREAK_EXIT]
			&& !brk_set)
		begin
			s_d.brk_exit = 1'b0;
		end
		if (reg_write && reg_addr == stop_reset_pkg::ADDR_BREAK_CTL)
		begin
			s_d.brk_clear = reg_wdata[stop_reset_pkg::BIT_BREAK_CLEAR];
		end
		if (reg_read)
		begin
			unique case (reg_addr)
				stop_reset_pkg::ADDR_BREAK_EXIT:
				begin
					s_d.rdata[stop_reset_pkg::BIT_BREAK_EXIT] = s_q.brk_exit;
				end
				stop_reset_pkg::ADDR_RESET_SRC:
				begin
					s_d.rdata = s_q.rsrc;
					s_d.rsrc = stop_reset_pkg::BYTE_ZERO;
				end
				stop_reset_pkg::ADDR_BREAK_CTL:
				begin
					s_d.rdata[stop_reset_pkg::BIT_BREAK_CLEAR] = s_q.brk_clear;
				end
				default:
				begin
					s_d.rdata = stop_reset_pkg::BYTE_ZERO;
				end
			endcase
		end
		// reset source latching; a new reset replaces the record
		if (any_reset)
		begin
			s_d.rsrc = stop_reset_pkg::BYTE_ZERO;
			s_d.rsrc[stop_reset_pkg::BIT_PIN] = pin_reset;
			s_d.rsrc[stop_reset_pkg::BIT_WDOG] = wdog_reset;
			s_d.rsrc[stop_reset_pkg::BIT_ILLEGAL_OPCODE_FLAG] = illegal_opcode_flag_reset;
			s_d.rsrc[stop_reset_pkg::BIT_ILLEGAL_ADDRESS_FLAG] = illegal_address_flag_fetch_reset;
			s_d.rsrc[stop_reset_pkg::BIT_MONITOR_ENTRY_FLAG] = monitor_entry_flag_reset;
			s_d.rsrc[stop_reset_pkg::BIT_LOWV] = lvi_reset;
			s_d.brk_exit = 1'b0;
		end
		if (por_event)
		begin
			s_d.rsrc = stop_reset_pkg::RESET_SRC_POR;
			s_d.brk_exit = 1'b0;
		end
		// flags elsewhere clear in break only when enabled
		s_d.fca = !break_request || s_d.brk_clear;
	end

	// ==========================================================
	// state register
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			s_q <= '0;
			s_q.mode <= run_s;
			s_q.clk_en <= 1'b1;
			s_q.fca <= 1'b1;
			s_q.rsrc <= stop_reset_pkg::RESET_SRC_POR;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign reg_rdata = s_q.rdata;
	assign clocks_enable = s_q.clk_en;
	assign divided_osc_enable = s_q.clk_en;
	assign cpu_release = s_q.release_p;
	assign in_stop = s_q.stopped;
	assign flag_clear_allowed = s_q.fca;

	// ==========================================================
	// checks
	property p_stop_entry;
		@(posedge clock) disable iff (srst)
		(s_q.mode == run_s && stop_exec) |=> !clocks_enable && s_q.count == '0;
	endproperty
	a_stop_entry: assert property (p_stop_entry)
		else $error("stop entry did not gate clocks");
	property p_hold;
		@(posedge clock) disable iff (srst)
		(s_q.mode == stop_s) |-> s_q.count == '0;
	endproperty
	a_hold: assert property (p_hold)
		else $error("counter not held in stop");
	property p_no_early;
		@(posedge clock) disable iff (srst)
		cpu_release |-> $past(s_q.count) >= stop_reset_pkg::RECOVERY_SHORT;
	endproperty
	a_no_early: assert property (p_no_early)
		else $error("release before recovery");
	property p_clk_off;
		@(posedge clock) disable iff (srst)
		(s_q.mode == stop_s) |-> !divided_osc_enable;
	endproperty
	a_clk_off: assert property (p_clk_off)
		else $error("osc clock running in stop");
	property p_brk_stop;
		@(posedge clock) disable iff (srst)
		(s_q.mode == stop_s && break_request && !any_reset && !por_event)
		|=> s_q.brk_exit;
	endproperty
	a_brk_stop: assert property (p_brk_stop)
		else $error("break exit flag not set");
	property p_rsr_clear;
		@(posedge clock) disable iff (srst)
		(reg_read && reg_addr == stop_reset_pkg::ADDR_RESET_SRC
			&& !any_reset && !por_event)
		|=> s_q.rsrc == stop_reset_pkg::BYTE_ZERO;
	endproperty
	a_rsr_clear: assert property (p_rsr_clear)
		else $error("reset source not cleared by read");
	property p_por;
		@(posedge clock) disable iff (srst)
		por_event |=> s_q.rsrc == stop_reset_pkg::RESET_SRC_POR;
	endproperty
	a_por: assert property (p_por)
		else $error("por flag wrong");
	property p_wdog;
		@(posedge clock) disable iff (srst)
		(wdog_reset && !por_event) |=> s_q.rsrc[stop_reset_pkg::BIT_WDOG];
	endproperty
	a_wdog: assert property (p_wdog)
		else $error("watchdog flag not set");
	property p_protect;
		@(posedge clock) disable iff (srst)
		(break_request && !s_d.brk_clear) |=> !flag_clear_allowed;
	endproperty
	a_protect: assert property (p_protect)
		else $error("flags clearable in break");
	property p_release_time;
		@(posedge clock) disable iff (srst)
		(s_q.mode == recover_s && s_q.count < target) |=> !cpu_release;
	endproperty
	a_release_time: assert property (p_release_time)
		else $error("release before full recovery count");
	property p_release_one;
		@(posedge clock) disable iff (srst)
		cpu_release |=> !cpu_release;
	endproperty
	a_release_one: assert property (p_release_one)
		else $error("release pulse longer than one cycle");
	property p_release_clk;
		@(posedge clock) disable iff (srst)
		cpu_release |-> clocks_enable && !in_stop;
	endproperty
	a_release_clk: assert property (p_release_clk)
		else $error("clocks not restored at release");
	property p_wake_exit;
		@(posedge clock) disable iff (srst)
		(s_q.mode == stop_s && wake) |=> s_q.mode == recover_s;
	endproperty
	a_wake_exit: assert property (p_wake_exit)
		else $error("wake request did not end stop");
	property p_recover_clk;
		@(posedge clock) disable iff (srst)
		(s_q.mode == recover_s) |-> !clocks_enable && s_q.wake_irq;
	endproperty
	a_recover_clk: assert property (p_recover_clk)
		else $error("clocks running during recovery");
	property p_count_step;
		@(posedge clock) disable iff (srst)
		(s_q.mode == recover_s && !slow_rise && s_q.count < target)
		|=> $stable(s_q.count);
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("counter moved without slow edge");
	property p_count_inc;
		@(posedge clock) disable iff (srst)
		(s_q.mode == recover_s && slow_rise && s_q.count < target)
		|=> s_q.count == $past(s_q.count)
			+ stop_reset_pkg::RECOVERY_ONE;
	endproperty
	a_count_inc: assert property (p_count_inc)
		else $error("counter missed a slow edge");
	property p_wait_brk;
		@(posedge clock) disable iff (srst)
		(s_q.mode == run_s && !stop_exec && s_q.in_wait && break_request
			&& !any_reset && !por_event)
		|=> s_q.brk_exit;
	endproperty
	a_wait_brk: assert property (p_wait_brk)
		else $error("break exit from wait not flagged");
	property p_brk_wr_clr;
		@(posedge clock) disable iff (srst)
		(reg_write && reg_addr == stop_reset_pkg::ADDR_BREAK_EXIT
			&& !reg_wdata[stop_reset_pkg::BIT_BREAK_EXIT] && !brk_set)
		|=> !s_q.brk_exit;
	endproperty
	a_brk_wr_clr: assert property (p_brk_wr_clr)
		else $error("write zero did not clear break flag");
	property p_reset_clr;
		@(posedge clock) disable iff (srst)
		(any_reset || por_event) |=> !s_q.brk_exit;
	endproperty
	a_reset_clr: assert property (p_reset_clr)
		else $error("reset did not clear break flag");
	property p_pin;
		@(posedge clock) disable iff (srst)
		(pin_reset && !por_event) |=> s_q.rsrc[stop_reset_pkg::BIT_PIN];
	endproperty
	a_pin: assert property (p_pin)
		else $error("pin flag not set");
	property p_illegal_opcode_flag;
		@(posedge clock) disable iff (srst)
		(illegal_opcode_flag_reset && !por_event) |=> s_q.rsrc[stop_reset_pkg::BIT_ILLEGAL_OPCODE_FLAG];
	endproperty
	a_illegal_opcode_flag: assert property (p_illegal_opcode_flag)
		else $error("illegal opcode flag not set");
	property p_illegal_address_flag;
		@(posedge clock) disable iff (srst)
		(illegal_address_flag_fetch_reset && !por_event) |=> s_q.rsrc[stop_reset_pkg::BIT_ILLEGAL_ADDRESS_FLAG];
	endproperty
	a_illegal_address_flag: assert property (p_illegal_address_flag)
		else $error("illegal address flag not set");
	property p_monitor_entry_flag;
		@(posedge clock) disable iff (srst)
		(monitor_entry_flag_reset && !por_event) |=> s_q.rsrc[stop_reset_pkg::BIT_MONITOR_ENTRY_FLAG];
	endproperty
	a_monitor_entry_flag: assert property (p_monitor_entry_flag)
		else $error("monitor entry flag not set");
	property p_lowv;
		@(posedge clock) disable iff (srst)
		(lvi_reset && !por_event) |=> s_q.rsrc[stop_reset_pkg::BIT_LOWV];
	endproperty
	a_lowv: assert property (p_lowv)
		else $error("low-voltage flag not set");
endmodule : stop_reset_status

// [core/stop_reset_pkg.sv]
// constants for the stop-mode and reset-status block
// assumes one 20 MHz clock; slow clock arrives as a sync level input
package stop_reset_pkg;
	localparam logic [1:0] ADDR_BREAK_EXIT = 2'h0;
	localparam logic [1:0] ADDR_RESET_SRC = 2'h1;
	localparam logic [1:0] ADDR_BREAK_CTL = 2'h2;
	localparam int BIT_BREAK_EXIT = 1;
	localparam int BIT_BREAK_CLEAR = 0;
	localparam int BIT_POR = 7;
	localparam int BIT_PIN = 6;
	localparam int BIT_WDOG = 5;
	localparam int BIT_ILLEGAL_OPCODE_FLAG = 4;
	localparam int BIT_ILLEGAL_ADDRESS_FLAG = 3;
	localparam int BIT_MONITOR_ENTRY_FLAG = 2;
	localparam int BIT_LOWV = 1;
	localparam logic [12:0] RECOVERY_LONG = 13'h1000;
	localparam logic [12:0] RECOVERY_SHORT = 13'h0020;
	localparam logic [12:0] RECOVERY_ONE = 13'h0001;
	localparam logic [7:0] RESET_SRC_POR = 8'h80;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] VECTOR_BLANK = 8'hff;
endpackage : stop_reset_pkg

// [bench/slow_osc_model.sv]
// model of the slow oscillator and config bit at the stop block
// assumes the bench clock; slow clock runs free, stop or not
`timescale 1ns/1ps
module slow_osc_model
(
	input wire logic clock,
	input wire logic canned_osc,
	output logic slow_clock,
	output logic short_recovery
);
	logic [1:0] div_q = 2'h0;
	// ========
	// one slow period per four clocks
	always_ff @(posedge clock)
	begin
		div_q <= div_q + 2'h1;
	end
	assign slow_clock = div_q[1];
	// crystal parts keep the short recovery clear
	assign short_recovery = canned_osc;
endmodule : slow_osc_model

// [bench/stop_reset_status_tb.sv]
// self-checking bench for the stop and reset status block
// assumes a 20 MHz clock and the slow oscillator model
`timescale 1ns/1ps
module stop_reset_status_tb;
	logic clock = 0, srst = 1, stop_exec = 0, wait_exec = 0;
	logic irq_request = 0, break_request = 0, canned = 0, por_event = 0;
	logic [5:0] cause = 6'h00;
	logic [1:0] reg_addr = 2'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata;
	logic reg_write = 0, reg_read = 0, slow, short;
	logic clocks_enable, divided_osc_enable, cpu_release, in_stop;
	logic flag_clear_allowed;
	int mismatches = 0, check_count = 0;
	slow_osc_model slow_osc_model_inst (.clock(clock), .canned_osc(canned),
		.slow_clock(slow), .short_recovery(short));
	stop_reset_status stop_reset_status_inst (.clock(clock), .srst(srst),
		.stop_exec(stop_exec), .wait_exec(wait_exec),
		.irq_request(irq_request), .break_request(break_request),
		.internal_slow_clock(slow), .short_stop_recovery(short),
		.por_event(por_event), .pin_reset(cause[0]),
		.wdog_reset(cause[1]), .illegal_opcode_flag_reset(cause[2]),
		.illegal_address_flag_fetch_reset(cause[3]), .monitor_entry_flag_reset(cause[4]),
		.lvi_reset(cause[5]), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.clocks_enable(clocks_enable),
		.divided_osc_enable(divided_osc_enable), .cpu_release(cpu_release),
		.in_stop(in_stop), .flag_clear_allowed(flag_clear_allowed));
	// ========
	// helpers
	initial
	begin
		forever #25 clock = ~clock;
	end
	task results;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results
	task check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check
	task wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1;
		@(posedge clock);
		reg_write <= 0;
	endtask : wr
	task rd(input logic [1:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1;
		@(posedge clock);
		reg_read <= 0;
		#1 check(reg_rdata, exp);
	endtask : rd
	task stop_run(input logic s, input logic brk, input int n);
		int cnt, t;
		logic prev, ce;
		cnt = 0;
		t = 0;
		prev = 1;
		ce = 0;
		@(posedge clock);
		canned <= s;
		stop_exec <= 1;
		@(posedge clock);
		stop_exec <= 0;
		repeat (3) @(posedge clock);
		#1 check({clocks_enable, divided_osc_enable, in_stop}, 8'h01);
		@(posedge clock);
		if (brk)
			break_request <= 1;
		else
			irq_request <= 1;
		while (cpu_release !== 1'b1 && t < 20000)
		begin
			@(posedge clock);
			#1;
			t++;
			if (slow === 1'b1 && prev === 1'b0)
				cnt++;
			prev = slow;
			if (cpu_release !== 1'b1 && clocks_enable !== 1'b0)
				ce = 1;
		end
		check(ce, 0);
		check(cnt >= n - 1 && cnt <= n + 1, 1);
		@(posedge clock);
		irq_request <= 0;
		#1 check({clocks_enable, in_stop, cpu_release}, 8'h04);
		$display("test stop %0d done", n);
	endtask : stop_run
	// ========
	// tests
	initial
	begin
		repeat (6) @(posedge clock);
		srst <= 0;
		rd(1, 8'h80);
		rd(1, 8'h00);
		rd(0, 8'h00);
		wr(3, 8'hff);
		rd(3, 8'h00);
		rd(2, 8'h00);
		for (int i = 0; i < 6; i++)
		begin
			@(posedge clock);
			cause <= 6'h01 << i;
			@(posedge clock);
			cause <= 6'h00;
			rd(1, 8'h40 >> i);
		end
		@(posedge clock);
		cause <= 6'h01;
		por_event <= 1;
		@(posedge clock);
		cause <= 6'h00;
		por_event <= 0;
		rd(1, 8'h80);
		$display("test sources done");
		stop_run(1, 0, 32);
		stop_run(0, 0, 4096);
		stop_run(1, 1, 32);
		check(flag_clear_allowed, 0);
		wr(2, 8'h01);
		rd(2, 8'h01);
		check(flag_clear_allowed, 1);
		rd(0, 8'h02);
		@(posedge clock);
		break_request <= 0;
		wr(2, 8'h00);
		wr(0, 8'h00);
		rd(0, 8'h00);
		@(posedge clock);
		wait_exec <= 1;
		@(posedge clock);
		wait_exec <= 0;
		break_request <= 1;
		repeat (3) @(posedge clock);
		break_request <= 0;
		rd(0, 8'h02);
		@(posedge clock);
		srst <= 1;
		@(posedge clock);
		srst <= 0;
		rd(0, 8'h00);
		rd(1, 8'h80);
		$display("test break done");
		results;
	end
	initial
	begin
		repeat (60000) @(posedge clock);
		mismatches++;
		results;
	end
endmodule : stop_reset_status_tb
